// File: vsc_slicer_config.sv
// Slicer configuration bank with AHB-Lite slave and per-line type lookup.
// Assumes line number, field and vblank flags and sliced bytes arrive on hclk.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module vsc_slicer_config (
  input  wire logic                  hclk,                // Bus and slicer clock
  input  wire logic                  hresetn,             // Async reset, low
  input  wire logic                  hsel,                // Slave select
  input  wire logic [9:0]            haddr,               // Byte address
  input  wire logic [1:0]            htrans,              // Transfer type
  input  wire logic                  hwrite,              // Write request
  input  wire logic [2:0]            hsize,               // Transfer size
  input  wire logic [31:0]           hwdata,              // Write data
  input  wire logic                  hready,              // Bus ready
  output logic                       hreadyout,           // Slave ready
  output logic                       hresp,               // Always OKAY
  output logic [31:0]                hrdata,              // Read data
  input  wire logic [8:0]            line_number,         // Line being sliced
  input  wire logic                  decoder_field_flag,  // Decoder field, 0 field 1
  input  wire logic                  decoder_vblank_flag, // Decoder vblank
  input  wire logic [7:0]            slice_byte,          // Raw sliced byte
  input  wire logic                  slice_byte_valid,    // Byte strobe
  output vsc_pkg::vsc_slice_cfg_t    slice_cfg,           // Per-line settings
  output logic [7:0]                 data_out,            // Recoded byte
  output logic                       data_out_valid       // Recoded byte strobe
);

  typedef struct packed {
    logic [vsc_pkg::NUM_LINES-1:0][7:0] lines;
    logic [7:0]                        sync;
    logic [7:0]                        slicer_horiz_offset_lo;
    logic [7:0]                        slicer_vert_offset_lo;
    logic [7:0]                        msbs;
    logic [7:0]                        hdr;
    logic [7:0]                        sliced_payload_ident;
    logic                              a_wr;
    logic [6:0]                        a_idx;
    logic [31:0]                       rdata;
    logic [8:0]                        cur_line;
    logic                              field_id_bit;
    vsc_pkg::vsc_slice_cfg_t           out;
    logic [7:0]                        data;
    logic                              data_vld;
  } vsc_state_t;

  vsc_state_t s;
  vsc_state_t next_s;

  // Sync pattern, fixed or the programmable sync byte, and its length in bits for a data type
  function automatic logic [28:0] vsc_sync(input logic [3:0] dt, input logic [7:0] prog);
    logic [28:0] r;
    r = {24'h000000, vsc_pkg::BITS_NONE};
    case (vsc_pkg::vsc_dtype_t'(dt))
      vsc_pkg::DT_TTX625, vsc_pkg::DT_TTX525: r = {vsc_pkg::SYNC_TTX, vsc_pkg::BITS_BYTE};
      vsc_pkg::DT_EU_CAPTION_TYPE, vsc_pkg::DT_US_CAPTION_TYPE:   r = {vsc_pkg::SYNC_CC, vsc_pkg::BITS_CC};
      vsc_pkg::DT_VPS:                        r = {vsc_pkg::SYNC_VPS, vsc_pkg::BITS_VPS};
      vsc_pkg::DT_WSS:                        r = {vsc_pkg::SYNC_WSS, vsc_pkg::BITS_WSS};
      vsc_pkg::DT_GTEXT, vsc_pkg::DT_TC625, vsc_pkg::DT_TC525,
      vsc_pkg::DT_JTEXT, vsc_pkg::DT_JFS:     r = {16'h0000, prog, vsc_pkg::BITS_BYTE};
      default:                                r = {24'h000000, vsc_pkg::BITS_NONE};
    endcase
    return r;
  endfunction : vsc_sync

  // Register readback, zero for unmapped indices
  function automatic logic [7:0] vsc_read(input logic [6:0] idx, input vsc_state_t st);
    logic [7:0] r;
    r = 8'h00;
    if (idx >= vsc_pkg::IDX_LINE_FIRST && idx <= vsc_pkg::IDX_LINE_LAST) begin
      r = st.lines[5'(idx - vsc_pkg::IDX_LINE_FIRST)];
    end else if (idx == vsc_pkg::IDX_SYNC) begin
      r = st.sync;
    end else if (idx == vsc_pkg::IDX_SLICER_HORIZ_OFFSET) begin
      r = st.slicer_horiz_offset_lo;
    end else if (idx == vsc_pkg::IDX_SLICER_VERT_OFFSET) begin
      r = st.slicer_vert_offset_lo;
    end else if (idx == vsc_pkg::IDX_MSBS) begin
      r = {st.msbs[7:6], 1'b0, st.msbs[4], 1'b0, st.msbs[2:0]};
    end else if (idx == vsc_pkg::IDX_HDR) begin
      r = {st.hdr[7], 1'b0, st.hdr[5:0]};
    end else if (idx == vsc_pkg::IDX_SLICED_PAYLOAD_IDENT) begin
      r = {2'b00, st.sliced_payload_ident[5:0]};
    end else if (idx == vsc_pkg::IDX_STAT1) begin
      r = {2'b00, st.field_id_bit, st.cur_line[8:4]};
    end else if (idx == vsc_pkg::IDX_STAT2) begin
      r = {st.cur_line[3:0], st.out.data_type};
    end
    return r;
  endfunction : vsc_read

  logic        field_eff;
  logic [3:0]  dt_next;
  logic [28:0] sync_next;
  logic [8:0]  slicer_vert_offset_raw;
  logic [4:0]  line_idx;

  always_comb begin
    next_s    = s;
    field_eff = decoder_field_flag ^ s.msbs[vsc_pkg::FINV_BIT];
    line_idx  = 5'(line_number - vsc_pkg::LINE_FIRST);
    dt_next   = vsc_pkg::DT_ACTIVE;
    sync_next = vsc_sync(dt_next, s.sync);
    slicer_vert_offset_raw  = {s.msbs[vsc_pkg::VMSB_BIT], s.slicer_vert_offset_lo};
    // Data phase write lands before the read mux sees the state
    if (s.a_wr) begin
      if (s.a_idx >= vsc_pkg::IDX_LINE_FIRST && s.a_idx <= vsc_pkg::IDX_LINE_LAST) begin
        next_s.lines[5'(s.a_idx - vsc_pkg::IDX_LINE_FIRST)] = hwdata[7:0];
      end else if (s.a_idx == vsc_pkg::IDX_SYNC) begin
        next_s.sync = hwdata[7:0];
      end else if (s.a_idx == vsc_pkg::IDX_SLICER_HORIZ_OFFSET) begin
        next_s.slicer_horiz_offset_lo = hwdata[7:0];
      end else if (s.a_idx == vsc_pkg::IDX_SLICER_VERT_OFFSET) begin
        next_s.slicer_vert_offset_lo = hwdata[7:0];
      end else if (s.a_idx == vsc_pkg::IDX_MSBS) begin
        next_s.msbs = hwdata[7:0];
      end else if (s.a_idx == vsc_pkg::IDX_HDR) begin
        next_s.hdr = hwdata[7:0];
      end else if (s.a_idx == vsc_pkg::IDX_SLICED_PAYLOAD_IDENT) begin
        next_s.sliced_payload_ident = hwdata[7:0];
      end
    end
    next_s.a_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_s.a_wr  = hwrite && !haddr[9];
      next_s.a_idx = haddr[8:2];
      next_s.rdata = haddr[9] ? 32'h00000000 : {24'h000000, vsc_read(haddr[8:2], next_s)};
    end
    // Line type selection by field
    if (line_number >= vsc_pkg::LINE_FIRST && line_number <= vsc_pkg::LINE_LAST) begin
      dt_next = field_eff ? s.lines[line_idx][3:0] : s.lines[line_idx][7:4];
    end
    sync_next = vsc_sync(dt_next, s.sync);
    next_s.cur_line          = line_number;
    next_s.field_id_bit      = field_eff;
    next_s.out.data_type     = dt_next;
    next_s.out.sync_pattern  = sync_next[28:5];
    next_s.out.sync_bits     = sync_next[4:0];
    next_s.out.sync_search   = (sync_next[4:0] != vsc_pkg::BITS_NONE);
    next_s.out.pass_video    = (dt_next == vsc_pkg::DT_TEST) ||
                               (dt_next == vsc_pkg::DT_ACTIVE);
    if (s.hdr[vsc_pkg::FV_REFERENCE_SELECT_BIT]) begin
      next_s.out.field_out  = decoder_field_flag;
      next_s.out.vblank_out = decoder_vblank_flag;
    end else begin
      next_s.out.field_out  = field_eff;
      next_s.out.vblank_out = (dt_next != vsc_pkg::DT_ACTIVE);
    end
    next_s.out.header_ident  = s.hdr[5:0];
    next_s.out.sav_eav_mode  = (s.hdr[5:0] == vsc_pkg::DID_SAV_REF1) ||
                               (s.hdr[5:0] == vsc_pkg::DID_SAV_REF0);
    next_s.out.payload_ident = s.sliced_payload_ident[5:0];
    next_s.out.horiz_offset  = {s.msbs[2:0], s.slicer_horiz_offset_lo};
    next_s.out.vert_offset   = (slicer_vert_offset_raw > vsc_pkg::SLICER_VERT_OFFSET_MAX) ? vsc_pkg::SLICER_VERT_OFFSET_MAX
                                                              : slicer_vert_offset_raw;
    // Byte recoding
    next_s.data_vld = slice_byte_valid;
    if (slice_byte_valid) begin
      next_s.data = slice_byte;
      if (s.msbs[vsc_pkg::REMAP_BIT] && slice_byte == vsc_pkg::BYTE_ZERO) begin
        next_s.data = vsc_pkg::BYTE_ZERO_MAP;
      end else if (s.msbs[vsc_pkg::REMAP_BIT] && slice_byte == vsc_pkg::BYTE_ONES) begin
        next_s.data = vsc_pkg::BYTE_ONES_MAP;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s       <= '0;
      s.lines <= {vsc_pkg::NUM_LINES{vsc_pkg::RST_LINE}};
      s.sync  <= vsc_pkg::RST_SYNC;
      s.slicer_horiz_offset_lo <= vsc_pkg::RST_SLICER_HORIZ_OFFSET;
      s.slicer_vert_offset_lo <= vsc_pkg::RST_SLICER_VERT_OFFSET;
      s.msbs  <= vsc_pkg::RST_MSBS;
      s.hdr   <= vsc_pkg::RST_HDR;
      s.sliced_payload_ident  <= vsc_pkg::RST_SLICED_PAYLOAD_IDENT;
      s.out.data_type <= vsc_pkg::DT_ACTIVE;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = s.rdata;
  assign slice_cfg      = s.out;
  assign data_out       = s.data;
  assign data_out_valid = s.data_vld;

  property p_wss_sync;
    @(posedge hclk) disable iff (!hresetn)
    s.out.data_type == vsc_pkg::DT_WSS |->
      s.out.sync_pattern == vsc_pkg::SYNC_WSS && s.out.sync_bits == vsc_pkg::BITS_WSS;
  endproperty
  a_wss_sync: assert property (p_wss_sync) else $error("wss sync wrong");

  property p_cc_sync;
    @(posedge hclk) disable iff (!hresetn)
    s.out.data_type == vsc_pkg::DT_US_CAPTION_TYPE |->
      s.out.sync_pattern == vsc_pkg::SYNC_CC && s.out.sync_bits == vsc_pkg::BITS_CC;
  endproperty
  a_cc_sync: assert property (p_cc_sync) else $error("caption sync wrong");

  property p_test_pass;
    @(posedge hclk) disable iff (!hresetn)
    s.out.data_type == vsc_pkg::DT_TEST |-> s.out.pass_video && !s.out.sync_search;
  endproperty
  a_test_pass: assert property (p_test_pass) else $error("test line searched");

  property p_out_range;
    @(posedge hclk) disable iff (!hresetn)
    (line_number < vsc_pkg::LINE_FIRST || line_number > vsc_pkg::LINE_LAST) |=>
      s.out.data_type == vsc_pkg::DT_ACTIVE && s.out.pass_video;
  endproperty
  a_out_range: assert property (p_out_range) else $error("outside line not active");

  property p_prog_sync;
    @(posedge hclk) disable iff (!hresetn)
    (s.out.data_type == vsc_pkg::DT_TC625 || s.out.data_type == vsc_pkg::DT_TC525 ||
     s.out.data_type == vsc_pkg::DT_JFS) |-> s.out.sync_pattern[7:0] == $past(s.sync);
  endproperty
  a_prog_sync: assert property (p_prog_sync) else $error("prog sync not used");

  property p_line21_f1;
    @(posedge hclk) disable iff (!hresetn)
    (line_number == 9'h015 && !field_eff) |=> s.out.data_type == $past(s.lines[19][7:4]);
  endproperty
  a_line21_f1: assert property (p_line21_f1) else $error("field 1 nibble wrong");

  property p_line21_f2;
    @(posedge hclk) disable iff (!hresetn)
    (line_number == 9'h015 && field_eff) |=> s.out.data_type == $past(s.lines[19][3:0]);
  endproperty
  a_line21_f2: assert property (p_line21_f2) else $error("field 2 nibble wrong");

  property p_remap_ff;
    @(posedge hclk) disable iff (!hresetn)
    slice_byte_valid && s.msbs[vsc_pkg::REMAP_BIT] && slice_byte == vsc_pkg::BYTE_ONES |=>
      data_out_valid && data_out == vsc_pkg::BYTE_ONES_MAP;
  endproperty
  a_remap_ff: assert property (p_remap_ff) else $error("ff not recoded");

  property p_no_remap;
    @(posedge hclk) disable iff (!hresetn)
    slice_byte_valid && !s.msbs[vsc_pkg::REMAP_BIT] |=> data_out == $past(slice_byte);
  endproperty
  a_no_remap: assert property (p_no_remap) else $error("byte altered");

  property p_vclamp;
    @(posedge hclk) disable iff (!hresetn)
    s.out.vert_offset <= vsc_pkg::SLICER_VERT_OFFSET_MAX;
  endproperty
  a_vclamp: assert property (p_vclamp) else $error("vertical offset over max");

  property p_fv_reference_select;
    @(posedge hclk) disable iff (!hresetn)
    s.hdr[vsc_pkg::FV_REFERENCE_SELECT_BIT] |=> s.out.field_out == $past(decoder_field_flag) &&
                                  s.out.vblank_out == $past(decoder_vblank_flag);
  endproperty
  a_fv_reference_select: assert property (p_fv_reference_select) else $error("fv not from decoder");

  property p_sav_mode;
    @(posedge hclk) disable iff (!hresetn)
    s.hdr[5:0] == vsc_pkg::DID_SAV_REF1 ##1 s.hdr[5:0] == vsc_pkg::DID_SAV_REF1 |->
      s.out.sav_eav_mode;
  endproperty
  a_sav_mode: assert property (p_sav_mode) else $error("sav mode missing");

  c_wss: cover property (@(posedge hclk) disable iff (!hresetn)
    s.out.data_type == vsc_pkg::DT_WSS);
  c_remap: cover property (@(posedge hclk) disable iff (!hresetn)
    data_out_valid && data_out == vsc_pkg::BYTE_ZERO_MAP);
  c_rd_stat: cover property (@(posedge hclk) disable iff (!hresetn)
    hsel && hready && htrans[1] && !hwrite && haddr[8:2] == vsc_pkg::IDX_STAT2);

endmodule : vsc_slicer_config

// File: vsc_pkg.sv
// Constants, encodings and carrier structs of the slicer configuration bank.
// Assumes a 32-bit AHB-Lite slave, each register in the low byte of one word.
// Function
// - One line type register per line 2..24; high nibble field 1, low field 2.
// - Type 0011 searches widescreen signalling with three-byte sync 1E3C1F.
// - Type 0101 decodes US captions on line 21 with sync 001.
// - Type 0110 passes a test-line video signal, no sync search.
// - Type 1111 is active video and the reset value of every line.
// - Type 1001 slices European time code with the programmable sync pattern.
// - Type 1010 slices US time code with the programmable sync pattern.
// - Type 1110 slices Japanese format switch with the programmable sync pattern.
// - Programmable sync pattern is eight bits, reset value 40H.
// - Horizontal offset is 11 bits, low byte plus 3-bit high part.
// - Vertical offset is 9 bits, low byte plus one bit, at most 312.
// - Field invert bit 7 inverts the internal field indicator.
// - Remap bit 6 turns data bytes 00H into 03H and FFH into FCH.
// - Reference select 0 takes field and vblank from table, 1 from decoder.
// - Header identifier 00 0000 frames output with ancillary headers.
// - Header identifier 3EH selects SAV/EAV framing, paired with reference 1.
// - Header identifier 3FH selects SAV/EAV framing, paired with reference 0.
// - Six-bit sliced payload identifier goes into headers, reset 00H.
// - Read-only status shows current line's data type code.
// - Status shows field bit, 0 for field 1, and 9-bit line number.
package vsc_pkg;
  localparam logic [6:0] IDX_LINE_FIRST = 7'h41;
  localparam logic [6:0] IDX_LINE_LAST  = 7'h57;
  localparam logic [6:0] IDX_SYNC       = 7'h58;
  localparam logic [6:0] IDX_SLICER_HORIZ_OFFSET       = 7'h59;
  localparam logic [6:0] IDX_SLICER_VERT_OFFSET       = 7'h5a;
  localparam logic [6:0] IDX_MSBS       = 7'h5b;
  localparam logic [6:0] IDX_HDR        = 7'h5d;
  localparam logic [6:0] IDX_SLICED_PAYLOAD_IDENT       = 7'h5e;
  localparam logic [6:0] IDX_STAT1      = 7'h61;
  localparam logic [6:0] IDX_STAT2      = 7'h62;
  localparam int         NUM_LINES      = 23;
  localparam logic [8:0] LINE_FIRST     = 9'h002;
  localparam logic [8:0] LINE_LAST      = 9'h018;
  localparam logic [8:0] SLICER_VERT_OFFSET_MAX       = 9'h138;
  localparam int         FINV_BIT       = 7;
  localparam int         REMAP_BIT      = 6;
  localparam int         VMSB_BIT       = 4;
  localparam int         FV_REFERENCE_SELECT_BIT      = 7;
  localparam logic [7:0] RST_LINE       = 8'hff;
  localparam logic [7:0] RST_SYNC       = 8'h40;
  localparam logic [7:0] RST_SLICER_HORIZ_OFFSET       = 8'h47;
  localparam logic [7:0] RST_SLICER_VERT_OFFSET       = 8'h03;
  localparam logic [7:0] RST_MSBS       = 8'h03;
  localparam logic [7:0] RST_HDR        = 8'h00;
  localparam logic [7:0] RST_SLICED_PAYLOAD_IDENT       = 8'h00;
  localparam logic [5:0] DID_SAV_REF1   = 6'h3e;
  localparam logic [5:0] DID_SAV_REF0   = 6'h3f;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] BYTE_ONES      = 8'hff;
  localparam logic [7:0] BYTE_ZERO_MAP  = 8'h03;
  localparam logic [7:0] BYTE_ONES_MAP  = 8'hfc;
  localparam logic [23:0] SYNC_TTX      = 24'h000027;
  localparam logic [23:0] SYNC_CC       = 24'h000001;
  localparam logic [23:0] SYNC_VPS      = 24'h009951;
  localparam logic [23:0] SYNC_WSS      = 24'h1e3c1f;
  localparam logic [4:0] BITS_NONE      = 5'h00;
  localparam logic [4:0] BITS_CC        = 5'h03;
  localparam logic [4:0] BITS_BYTE      = 5'h08;
  localparam logic [4:0] BITS_VPS       = 5'h10;
  localparam logic [4:0] BITS_WSS       = 5'h18;
  typedef enum logic [3:0] {
    DT_TTX625 = 4'h0, DT_EU_CAPTION_TYPE = 4'h1, DT_VPS = 4'h2, DT_WSS = 4'h3,
    DT_TTX525 = 4'h4, DT_US_CAPTION_TYPE = 4'h5, DT_TEST = 4'h6, DT_RAW = 4'h7,
    DT_GTEXT = 4'h8, DT_TC625 = 4'h9, DT_TC525 = 4'ha, DT_RSVD = 4'hb,
    DT_US_BROADCAST_TEXT_TYPE = 4'hc, DT_JTEXT = 4'hd, DT_JFS = 4'he, DT_ACTIVE = 4'hf
  } vsc_dtype_t;
  typedef struct packed {
    logic [3:0]  data_type;
    logic [23:0] sync_pattern;
    logic [4:0]  sync_bits;
    logic        sync_search;
    logic        pass_video;
    logic        field_out;
    logic        vblank_out;
    logic        sav_eav_mode;
    logic [5:0]  header_ident;
    logic [5:0]  payload_ident;
    logic [10:0] horiz_offset;
    logic [8:0]  vert_offset;
  } vsc_slice_cfg_t;
endpackage : vsc_pkg

// File: vsc_slicer_config_bench.sv
// Self-checking bench for the slicer configuration bank.
// Assumes one AHB-Lite master here, slave hreadyout looped back as hready.
`timescale 1ns/10ps
module vsc_slicer_config_bench;
  logic                   hclk = 1'b0;
  logic                   hresetn = 1'b0;
  logic                   hsel = 1'b0;
  logic [9:0]             haddr = 10'h000;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [2:0]             hsize = 3'h2;
  logic [31:0]            hwdata = 32'h0;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  logic [8:0]             line_number = 9'h000;
  logic                   field_flag = 1'b0;
  logic                   vblank_flag = 1'b0;
  logic [7:0]             slice_byte = 8'h00;
  logic                   slice_byte_valid = 1'b0;
  vsc_pkg::vsc_slice_cfg_t slice_cfg;
  logic [7:0]             data_out;
  logic                   data_out_valid;
  int                     n_errors = 0;
  int                     samples_checked = 0;
  int                     i;
  logic [31:0]            rd;
  logic [3:0]             lo;

  always #2 hclk = ~hclk;

  vsc_slicer_config DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_number(line_number),
    .decoder_field_flag(field_flag), .decoder_vblank_flag(vblank_flag),
    .slice_byte(slice_byte), .slice_byte_valid(slice_byte_valid),
    .slice_cfg(slice_cfg), .data_out(data_out), .data_out_valid(data_out_valid)
  );

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One single transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, {1'b0, idx, 2'b00}, {24'h0, d}, r);
  endtask : wr

  task automatic rd_chk(input string name, input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(name, r, exp);
  endtask : rd_chk

  // Drive slice inputs, then let the registered config land
  task automatic set_line(input logic [8:0] ln, input logic f, input logic vb);
    @(posedge hclk);
    line_number <= ln;
    field_flag <= f;
    vblank_flag <= vb;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask : set_line

  task automatic send_byte(input logic [7:0] b, input logic [7:0] exp);
    @(posedge hclk);
    slice_byte <= b;
    slice_byte_valid <= 1'b1;
    @(posedge hclk);
    slice_byte_valid <= 1'b0;
    @(negedge hclk);
    check("data_out_valid", {31'h0, data_out_valid}, 32'h1);
    check("data_out", {24'h0, data_out}, {24'h0, exp});
  endtask : send_byte

  task automatic set_slicer_vert_offset(input logic msb, input logic [7:0] low, input logic [8:0] exp);
    wr(vsc_pkg::IDX_SLICER_VERT_OFFSET, low);
    wr(vsc_pkg::IDX_MSBS, {3'h0, msb, 4'h3});
    set_line(9'h015, 1'b0, 1'b0);
    check("vert_offset", {23'h0, slice_cfg.vert_offset}, {23'h0, exp});
  endtask : set_slicer_vert_offset

  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    $display("unexpected watchdog: expected done seen hang");
    complete_run();
  end

  initial begin
    repeat (12) @(posedge hclk);
    check("reset_type", {28'h0, slice_cfg.data_type}, 32'hf);
    hresetn <= 1'b1;
    for (i = 0; i < 23; i++) rd_chk("line_rst", {1'b0, 7'h41 + 7'(i), 2'b00}, 32'hff);
    rd_chk("sync_rst", {1'b0, vsc_pkg::IDX_SYNC, 2'b00}, 32'h40);
    rd_chk("hdr_rst", {1'b0, vsc_pkg::IDX_HDR, 2'b00}, 32'h00);
    rd_chk("sliced_payload_ident_rst", {1'b0, vsc_pkg::IDX_SLICED_PAYLOAD_IDENT, 2'b00}, 32'h00);
    // Patterns keep every nibble clear of the reserved type
    for (i = 0; i < 23; i++) wr(7'h41 + 7'(i), {1'b0, 3'(i), 1'b0, 3'(i >> 3)});
    for (i = 0; i < 23; i++) rd_chk("line_rw", {1'b0, 7'h41 + 7'(i), 2'b00},
                                    {24'h0, 1'b0, 3'(i), 1'b0, 3'(i >> 3)});
    wr(vsc_pkg::IDX_MSBS, 8'hff);
    rd_chk("msbs_bits", {1'b0, vsc_pkg::IDX_MSBS, 2'b00}, 32'hd7);
    wr(vsc_pkg::IDX_HDR, 8'hff);
    rd_chk("hdr_bits", {1'b0, vsc_pkg::IDX_HDR, 2'b00}, 32'hbf);
    wr(vsc_pkg::IDX_SLICED_PAYLOAD_IDENT, 8'hff);
    rd_chk("sliced_payload_ident_bits", {1'b0, vsc_pkg::IDX_SLICED_PAYLOAD_IDENT, 2'b00}, 32'h3f);
    wr(7'h5c, 8'h5a);
    rd_chk("unmapped", {1'b0, 7'h5c, 2'b00}, 32'h0);
    rd_chk("unmapped_hi", 10'h304, 32'h0);
    wr(vsc_pkg::IDX_SLICER_HORIZ_OFFSET, 8'h47);
    set_slicer_vert_offset(1'b0, 8'h03, 9'd3);
    check("horiz_offset", {21'h0, slice_cfg.horiz_offset}, 32'h347);
    set_slicer_vert_offset(1'b0, 8'h06, 9'd6);
    set_slicer_vert_offset(1'b1, 8'h38, 9'd312);
    set_slicer_vert_offset(1'b1, 8'h3f, 9'd312);
    wr(vsc_pkg::IDX_HDR, 8'h00);
    wr(vsc_pkg::IDX_SYNC, 8'h5a);
    for (i = 0; i < 16; i++) begin
      if (i != 11) begin
        lo = (i == 4) ? 4'h4 : ~4'(i);
        wr(7'h54, {4'(i), lo});
        set_line(9'd21, 1'b0, 1'b0);
        check("dtype_f1", {28'h0, slice_cfg.data_type}, 32'(i));
        case (i)
          3: check("sync_wss", {8'h0, slice_cfg.sync_pattern}, 32'h1e3c1f);
          5: check("sync_cc", {8'h0, slice_cfg.sync_pattern}, 32'h1);
          6: check("no_search", {31'h0, slice_cfg.sync_search}, 32'h0);
          9, 10, 14: check("sync_prog", {8'h0, slice_cfg.sync_pattern}, 32'h5a);
          15: check("vblank_tab", {31'h0, slice_cfg.vblank_out}, 32'h0);
          default: check("vblank_tab", {31'h0, slice_cfg.vblank_out}, 32'h1);
        endcase
        set_line(9'd21, 1'b1, 1'b0);
        check("dtype_f2", {28'h0, slice_cfg.data_type}, {28'h0, lo});
      end
    end
    set_line(9'd1, 1'b0, 1'b0);
    check("line1", {28'h0, slice_cfg.data_type}, 32'hf);
    set_line(9'd2, 1'b0, 1'b0);
    check("line2", {28'h0, slice_cfg.data_type}, 32'h0);
    set_line(9'd24, 1'b0, 1'b0);
    check("line24", {28'h0, slice_cfg.data_type}, 32'h6);
    set_line(9'd25, 1'b0, 1'b0);
    check("line25", {28'h0, slice_cfg.data_type}, 32'hf);
    check("sav_off", {31'h0, slice_cfg.sav_eav_mode}, 32'h0);
    wr(vsc_pkg::IDX_HDR, 8'hbe);
    set_line(9'd21, 1'b1, 1'b1);
    check("sav_ref1", {26'h0, slice_cfg.sav_eav_mode, slice_cfg.header_ident}, 32'h7e);
    check("fv_dec1", {30'h0, slice_cfg.field_out, slice_cfg.vblank_out}, 32'h3);
    set_line(9'd25, 1'b0, 1'b0);
    check("fv_dec0", {30'h0, slice_cfg.field_out, slice_cfg.vblank_out}, 32'h0);
    wr(vsc_pkg::IDX_HDR, 8'h3f);
    wr(vsc_pkg::IDX_SLICED_PAYLOAD_IDENT, 8'h2a);
    set_line(9'd25, 1'b0, 1'b1);
    check("sav_ref0", {26'h0, slice_cfg.sav_eav_mode, slice_cfg.header_ident}, 32'h7f);
    check("vblank_ref0", {31'h0, slice_cfg.vblank_out}, 32'h0);
    check("payload_id", {26'h0, slice_cfg.payload_ident}, 32'h2a);
    send_byte(8'h00, 8'h00);
    send_byte(8'hff, 8'hff);
    wr(vsc_pkg::IDX_MSBS, 8'h43);
    send_byte(8'h00, 8'h03);
    send_byte(8'hff, 8'hfc);
    send_byte(8'h7e, 8'h7e);
    wr(7'h54, 8'h93);
    set_line(9'd21, 1'b0, 1'b0);
    rd_chk("stat1", {1'b0, vsc_pkg::IDX_STAT1, 2'b00}, 32'h01);
    rd_chk("stat2", {1'b0, vsc_pkg::IDX_STAT2, 2'b00}, 32'h59);
    wr(vsc_pkg::IDX_MSBS, 8'h83);
    set_line(9'd21, 1'b0, 1'b0);
    check("dtype_inv", {28'h0, slice_cfg.data_type}, 32'h3);
    rd_chk("stat1_inv", {1'b0, vsc_pkg::IDX_STAT1, 2'b00}, 32'h21);
    rd_chk("stat2_inv", {1'b0, vsc_pkg::IDX_STAT2, 2'b00}, 32'h53);
    complete_run();
  end
endmodule : vsc_slicer_config_bench
